// >>> pwr_cfg.svh
// Purpose: constants of the planar write/read datapath
// Assumes: host I/O decode on 16 address bits, 20-bit memory address
// Notes: definitions only
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH
`define PWR_IO_INDEX_PORT 16'h03CE
`define PWR_IO_DATA_PORT 16'h03CF
`define PWR_IDX_FILL_VALUE 4'h0
`define PWR_IDX_FILL_ENABLE 4'h1
`define PWR_IDX_COMPARE 4'h2
`define PWR_IDX_ROTATE 4'h3
`define PWR_IDX_READ_PLANE 4'h4
`define PWR_IDX_MODE 4'h5
`define PWR_IDX_WINDOW 4'h6
`define PWR_IDX_PARTICIPATE 4'h7
`define PWR_IDX_PROTECT 4'h8
`define PWR_MASK_NIBBLE 8'h0F
`define PWR_MASK_ROTATE 8'h1F
`define PWR_MASK_READ_PLANE 8'h03
`define PWR_MASK_MODE 8'h7B
`define PWR_MASK_FULL 8'hFF
`define PWR_MASK_NONE 8'h00
`define PWR_RESET_BYTE 8'h00
`define PWR_ROT_LSB 0
`define PWR_OP_LSB 3
`define PWR_WRITE_OP_LSB 0
`define PWR_COMPARE_SEL_BIT 3
`define PWR_ODD_EVEN_BIT 4
`define PWR_INTERLEAVE_BIT 5
`define PWR_WIDE_BIT 6
`define PWR_GFX_BIT 0
`define PWR_CHAIN_BIT 1
`define PWR_WINDOW_LSB 2
`define PWR_BASE_A0000 20'hA0000
`define PWR_BASE_B0000 20'hB0000
`define PWR_BASE_B8000 20'hB8000
`define PWR_SIZE_128K 20'h20000
`define PWR_SIZE_64K 20'h10000
`define PWR_SIZE_32K 20'h08000
`define PWR_READ_LATENCY 3
`endif

// >>> pwr_datapath.sv
// Purpose: planar write/read datapath with index/data register pair
// Assumes: host strobes and map memory run on clock_i; map read data
//   is valid the cycle after map_req_o.rd
// Notes: reads take three cycles, writes one; requests are dropped while busy
`timescale 1ns/1ps
`default_nettype none
`include "pwr_cfg.svh"
module pwr_datapath (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire pwr_pkg::pwr_byte_t io_wdata_i,
  output pwr_pkg::pwr_byte_t io_rdata_o,
  output logic io_rvalid_o,
  input wire logic mem_wr_i,
  input wire logic mem_rd_i,
  input wire logic [19:0] mem_addr_i,
  input wire pwr_pkg::pwr_byte_t mem_wdata_i,
  input wire logic seq_chain4_i,
  output pwr_pkg::pwr_byte_t mem_rdata_o,
  output logic mem_ack_o,
  output logic mem_busy_o,
  output pwr_pkg::pwr_map_req_s map_req_o,
  input wire logic [31:0] map_rdata_i,
  output pwr_pkg::pwr_disp_s disp_o
);
  import pwr_pkg::*;

  pwr_state_s st_reg;
  pwr_state_s st_next;
  pwr_cfg_s cfg;
  logic idx_valid;
  logic io_index_hit;
  logic io_data_hit;
  logic [19:0] win_base;
  logic [19:0] win_size;
  logic [19:0] offset;
  logic in_win;
  logic [15:0] map_addr;
  logic [3:0] plane_we;
  logic [1:0] rd_plane;
  logic rd_take;
  logic wr_take;
  logic [31:0] write_data;
  pwr_byte_t read_byte;

  function automatic pwr_byte_t reg_mask(input logic [3:0] idx);
    case (idx)
      `PWR_IDX_FILL_VALUE, `PWR_IDX_FILL_ENABLE, `PWR_IDX_COMPARE, `PWR_IDX_WINDOW,
      `PWR_IDX_PARTICIPATE: reg_mask = `PWR_MASK_NIBBLE;
      `PWR_IDX_ROTATE: reg_mask = `PWR_MASK_ROTATE;
      `PWR_IDX_READ_PLANE: reg_mask = `PWR_MASK_READ_PLANE;
      `PWR_IDX_MODE: reg_mask = `PWR_MASK_MODE;
      `PWR_IDX_PROTECT: reg_mask = `PWR_MASK_FULL;
      default: reg_mask = `PWR_MASK_NONE;
    endcase
  endfunction : reg_mask

  always_comb begin
    cfg.fill_bits = st_reg.regs[`PWR_IDX_FILL_VALUE][3:0];
    cfg.fill_en = st_reg.regs[`PWR_IDX_FILL_ENABLE][3:0];
    cfg.compare_bits = st_reg.regs[`PWR_IDX_COMPARE][3:0];
    cfg.logic_op = pwr_logic_op_e'(st_reg.regs[`PWR_IDX_ROTATE][`PWR_OP_LSB +: 2]);
    cfg.rotate_amount = st_reg.regs[`PWR_IDX_ROTATE][`PWR_ROT_LSB +: 3];
    cfg.read_plane_field = st_reg.regs[`PWR_IDX_READ_PLANE][1:0];
    cfg.wide_colour_load = st_reg.regs[`PWR_IDX_MODE][`PWR_WIDE_BIT];
    cfg.interleave_shift = st_reg.regs[`PWR_IDX_MODE][`PWR_INTERLEAVE_BIT];
    cfg.odd_even_mode = st_reg.regs[`PWR_IDX_MODE][`PWR_ODD_EVEN_BIT];
    cfg.read_compare_select = st_reg.regs[`PWR_IDX_MODE][`PWR_COMPARE_SEL_BIT];
    cfg.write_op_select =
      pwr_write_op_e'(st_reg.regs[`PWR_IDX_MODE][`PWR_WRITE_OP_LSB +: 2]);
    cfg.host_window_field = st_reg.regs[`PWR_IDX_WINDOW][`PWR_WINDOW_LSB +: 2];
    cfg.chain_odd_even = st_reg.regs[`PWR_IDX_WINDOW][`PWR_CHAIN_BIT];
    cfg.graphics_addressing = st_reg.regs[`PWR_IDX_WINDOW][`PWR_GFX_BIT];
    cfg.compare_participation = st_reg.regs[`PWR_IDX_PARTICIPATE][3:0];
    cfg.write_bit_protect = st_reg.regs[`PWR_IDX_PROTECT];
  end

  assign idx_valid = (st_reg.index <= `PWR_IDX_PROTECT);
  assign io_index_hit = (io_addr_i == `PWR_IO_INDEX_PORT);
  assign io_data_hit = (io_addr_i == `PWR_IO_DATA_PORT);

  // host memory window and map addressing
  always_comb begin
    case (cfg.host_window_field)
      2'h0: begin
        win_base = `PWR_BASE_A0000;
        win_size = `PWR_SIZE_128K;
      end
      2'h1: begin
        win_base = `PWR_BASE_A0000;
        win_size = `PWR_SIZE_64K;
      end
      2'h2: begin
        win_base = `PWR_BASE_B0000;
        win_size = `PWR_SIZE_32K;
      end
      default: begin
        win_base = `PWR_BASE_B8000;
        win_size = `PWR_SIZE_32K;
      end
    endcase
    offset = mem_addr_i - win_base;
    in_win = (mem_addr_i >= win_base) && (offset < win_size);
    map_addr = offset[15:0];
    plane_we = 4'hF;
    rd_plane = cfg.read_plane_field;
    if (seq_chain4_i) begin
      plane_we = 4'(4'h1 << offset[1:0]);
      rd_plane = offset[1:0];
    end else if (cfg.chain_odd_even) begin
      // A0 steers the map; offset bit 16, the top bit of the 128K window, takes its place
      map_addr = {offset[15:1], offset[16]};
      plane_we = offset[0] ? 4'hA : 4'h5;
      rd_plane = {cfg.read_plane_field[1], offset[0]};
    end else if (cfg.odd_even_mode) begin
      // software keeps this bit equal to the sequencer's copy
      rd_plane = {cfg.read_plane_field[1], offset[0]};
    end
  end

  // reads win a same-cycle tie; nothing is taken while a read is open
  assign rd_take = (st_reg.phase == PH_IDLE) && mem_rd_i && in_win;
  assign wr_take = (st_reg.phase == PH_IDLE) && !mem_rd_i && mem_wr_i && in_win;

  pwr_write_unit u_write (
    .cfg_i(cfg),
    .host_i(mem_wdata_i),
    .latch_i(st_reg.latch),
    .data_o(write_data)
  );

  pwr_read_unit u_read (
    .map_data_i(map_rdata_i),
    .plane_i(st_reg.rd_plane),
    .compare_i(st_reg.rd_compare),
    .compare_bits_i(cfg.compare_bits),
    .participation_i(cfg.compare_participation),
    .byte_o(read_byte)
  );

  always_comb begin
    st_next = st_reg;
    st_next.io_rvalid = 1'b0;
    st_next.mem_ack = 1'b0;
    st_next.map_req.rd = 1'b0;
    st_next.map_req.we = 4'h0;
    if (io_wr_i && io_index_hit) begin
      st_next.index = io_wdata_i[3:0];
    end
    if (io_wr_i && io_data_hit && idx_valid) begin
      st_next.regs[st_reg.index] = io_wdata_i & reg_mask(st_reg.index);
    end
    if (io_rd_i && io_index_hit) begin
      st_next.io_rdata = {4'h0, st_reg.index};
      st_next.io_rvalid = 1'b1;
    end else if (io_rd_i && io_data_hit) begin
      st_next.io_rdata = idx_valid ? st_reg.regs[st_reg.index] : `PWR_RESET_BYTE;
      st_next.io_rvalid = 1'b1;
    end
    case (st_reg.phase)
      PH_IDLE: begin
        if (rd_take) begin
          st_next.map_req.rd = 1'b1;
          st_next.map_req.addr = map_addr;
          st_next.rd_plane = rd_plane;
          st_next.rd_compare = cfg.read_compare_select;
          st_next.phase = PH_ISSUE;
          st_next.busy = 1'b1;
        end else if (wr_take) begin
          st_next.map_req.we = plane_we;
          st_next.map_req.addr = map_addr;
          st_next.map_req.wdata = write_data;
          st_next.mem_ack = 1'b1;
        end
      end
      PH_ISSUE: st_next.phase = PH_WAIT;
      PH_WAIT: begin
        st_next.latch = map_rdata_i;
        st_next.mem_rdata = read_byte;
        st_next.mem_ack = 1'b1;
        st_next.phase = PH_IDLE;
        st_next.busy = 1'b0;
      end
      default: begin
        st_next.phase = PH_IDLE;
        st_next.busy = 1'b0;
      end
    endcase
    if (cfg.wide_colour_load) begin
      st_next.disp.load_format = LOAD_WIDE;
    end else if (cfg.interleave_shift) begin
      st_next.disp.load_format = LOAD_INTERLEAVE;
    end else begin
      st_next.disp.load_format = LOAD_PLANAR;
    end
    st_next.disp.graphics_addressing = cfg.graphics_addressing;
    st_next.disp.char_latch_disable = cfg.graphics_addressing;
  end

  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata_o = st_reg.io_rdata;
  assign io_rvalid_o = st_reg.io_rvalid;
  assign mem_rdata_o = st_reg.mem_rdata;
  assign mem_ack_o = st_reg.mem_ack;
  assign mem_busy_o = st_reg.busy;
  assign map_req_o = st_reg.map_req;
  assign disp_o = st_reg.disp;

  // checker helpers
  logic [31:0] fill_word;
  assign fill_word = {{8{cfg.fill_bits[3]}}, {8{cfg.fill_bits[2]}},
                      {8{cfg.fill_bits[1]}}, {8{cfg.fill_bits[0]}}};

  AST_INDEX_LOAD: assert property (@(posedge clock_i) disable iff (reset_i)
    io_wr_i && io_index_hit |=> {4'h0, st_reg.index} == ($past(io_wdata_i) & 8'h0F))
    else $error("index not loaded from the index port");

  AST_READBACK_ZERO: assert property (@(posedge clock_i) disable iff (reset_i)
    io_rd_i && io_data_hit && st_reg.index == `PWR_IDX_ROTATE
    |=> io_rvalid_o && io_rdata_o[7:5] == 3'h0)
    else $error("rotate register readback wrong");

  AST_UNIMPL_WRITE: assert property (@(posedge clock_i) disable iff (reset_i)
    io_wr_i && io_data_hit && st_reg.index > `PWR_IDX_PROTECT |=> $stable(st_reg.regs))
    else $error("write to unimplemented index changed a register");

  AST_MODE0_FILL: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_take && cfg.write_op_select == WOP_ROTATED && cfg.fill_en == 4'hF
    && cfg.logic_op == OP_PASS && cfg.write_bit_protect == 8'hFF
    |=> map_req_o.wdata == $past(fill_word))
    else $error("mode 0 fill data wrong");

  AST_ROTATE_ONE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_take && cfg.write_op_select == WOP_ROTATED && cfg.fill_en == 4'h0
    && cfg.logic_op == OP_PASS && cfg.write_bit_protect == 8'hFF && cfg.rotate_amount == 3'h1
    |=> map_req_o.wdata[7:0] == {$past(mem_wdata_i[0]), $past(mem_wdata_i[7:1])})
    else $error("rotate by one wrong");

  AST_LATCH_COPY: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_take && cfg.write_op_select == WOP_LATCH
    |=> map_req_o.wdata == $past(st_reg.latch) && map_req_o.we != 4'h0 && mem_ack_o)
    else $error("mode 1 did not store the latches");

  AST_BIT_FILL_XOR: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_take && cfg.write_op_select == WOP_BIT_FILL && cfg.logic_op == OP_XOR
    && cfg.write_bit_protect == 8'hFF && mem_wdata_i[3:0] == 4'hF
    |=> map_req_o.wdata == ~$past(st_reg.latch))
    else $error("mode 2 with xor wrong");

  AST_WINDOW_B8: assert property (@(posedge clock_i) disable iff (reset_i)
    (mem_rd_i || mem_wr_i) && cfg.host_window_field == 2'h3 && mem_addr_i < 20'hB8000
    |=> !map_req_o.rd && map_req_o.we == 4'h0)
    else $error("access outside the window reached the maps");

  AST_ODD_EVEN_WE: assert property (@(posedge clock_i) disable iff (reset_i)
    wr_take && cfg.chain_odd_even && !seq_chain4_i
    |=> map_req_o.we == ($past(mem_addr_i[0]) ? 4'hA : 4'h5))
    else $error("odd/even plane select wrong");

  AST_READ_LATENCY: assert property (@(posedge clock_i) disable iff (reset_i)
    rd_take |=> map_req_o.rd ##2 (mem_ack_o && st_reg.latch == $past(map_rdata_i)))
    else $error("read did not complete in three cycles");

  AST_COMPARE_ALL: assert property (@(posedge clock_i) disable iff (reset_i)
    $past(st_reg.phase) == PH_WAIT && $past(st_reg.rd_compare)
    && $past(cfg.compare_participation) == 4'hF && $past(cfg.compare_bits) == 4'h0
    |-> mem_rdata_o == ~(st_reg.latch[31:24] | st_reg.latch[23:16]
                         | st_reg.latch[15:8] | st_reg.latch[7:0]))
    else $error("colour compare result wrong");
endmodule : pwr_datapath
`default_nettype wire

// >>> pwr_map_model.sv
// Purpose: behavioural model of the four video maps behind the datapath
// Assumes: low byte of the map address selects a word; plane n in bits 8n+7..8n
// Notes: read data is valid one cycle after rd and scrambled otherwise
`timescale 1ns/1ps
`default_nettype none
module pwr_map_model (
  input wire logic clock_i,
  input wire pwr_pkg::pwr_map_req_s req_i,
  output logic [31:0] rdata_o
);
  import pwr_pkg::*;
  logic [31:0] store [256];
  initial rdata_o = 32'h0000_0000;
  always @(posedge clock_i) begin
    for (int n = 0; n < 4; n++) begin
      if (req_i.we[n]) begin
        store[req_i.addr[7:0]][8*n +: 8] <= req_i.wdata[8*n +: 8];
      end
    end
    // stale data is inverted so a late sample cannot pass by luck
    rdata_o <= req_i.rd ? store[req_i.addr[7:0]] : ~rdata_o;
  end
endmodule : pwr_map_model
`default_nettype wire

// >>> pwr_pkg.sv
// Purpose: types shared by the planar write/read datapath
// Assumes: four 8-bit maps
// Notes: constants live in pwr_cfg.svh
`default_nettype none
package pwr_pkg;
  typedef logic [7:0] pwr_byte_t;
  typedef pwr_byte_t [8:0] pwr_regs_t;
  typedef enum logic [1:0] {OP_PASS, OP_AND, OP_OR, OP_XOR} pwr_logic_op_e;
  typedef enum logic [1:0] {WOP_ROTATED, WOP_LATCH, WOP_BIT_FILL, WOP_MASKED_FILL} pwr_write_op_e;
  typedef enum logic [1:0] {PH_IDLE, PH_ISSUE, PH_WAIT} pwr_phase_e;
  typedef enum logic [1:0] {LOAD_PLANAR, LOAD_INTERLEAVE, LOAD_WIDE} pwr_load_fmt_e;
  typedef struct packed {
    logic [3:0] fill_bits;
    logic [3:0] fill_en;
    logic [3:0] compare_bits;
    pwr_logic_op_e logic_op;
    logic [2:0] rotate_amount;
    logic [1:0] read_plane_field;
    logic wide_colour_load;
    logic interleave_shift;
    logic odd_even_mode;
    logic read_compare_select;
    pwr_write_op_e write_op_select;
    logic [1:0] host_window_field;
    logic chain_odd_even;
    logic graphics_addressing;
    logic [3:0] compare_participation;
    pwr_byte_t write_bit_protect;
  } pwr_cfg_s;
  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic [3:0] we;
    logic [31:0] wdata;
  } pwr_map_req_s;
  typedef struct packed {
    pwr_load_fmt_e load_format;
    logic graphics_addressing;
    logic char_latch_disable;
  } pwr_disp_s;
  typedef struct packed {
    pwr_regs_t regs;
    logic [3:0] index;
    pwr_byte_t io_rdata;
    logic io_rvalid;
    logic [31:0] latch;
    pwr_phase_e phase;
    logic busy;
    logic [1:0] rd_plane;
    logic rd_compare;
    pwr_map_req_s map_req;
    pwr_byte_t mem_rdata;
    logic mem_ack;
    pwr_disp_s disp;
  } pwr_state_s;
endpackage : pwr_pkg
`default_nettype wire

// >>> pwr_read_unit.sv
// Purpose: read-side byte selection and colour compare
// Assumes: map data holds plane n in bits 8n+7..8n
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module pwr_read_unit (
  input wire logic [31:0] map_data_i,
  input wire logic [1:0] plane_i,
  input wire logic compare_i,
  input wire logic [3:0] compare_bits_i,
  input wire logic [3:0] participation_i,
  output pwr_pkg::pwr_byte_t byte_o
);
  import pwr_pkg::*;
  pwr_byte_t match;
  genvar b;
  generate
    for (b = 0; b < 8; b++) begin : g_bit
      // a plane left out of the compare can never break a match
      assign match[b] = &(~({map_data_i[24+b], map_data_i[16+b], map_data_i[8+b],
                             map_data_i[b]} ^ compare_bits_i) | ~participation_i);
    end
  endgenerate
  assign byte_o = compare_i ? match : map_data_i[{plane_i, 3'b000} +: 8];
endmodule : pwr_read_unit
`default_nettype wire

// >>> pwr_write_unit.sv
// Purpose: write-side data path for the four maps
// Assumes: latch holds the bytes of the last host read
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "pwr_cfg.svh"
module pwr_write_unit (
  input wire pwr_pkg::pwr_cfg_s cfg_i,
  input wire pwr_pkg::pwr_byte_t host_i,
  input wire logic [31:0] latch_i,
  output logic [31:0] data_o
);
  import pwr_pkg::*;
  pwr_byte_t rotated;
  // right rotate: low byte of the doubled byte shifted down
  assign rotated = pwr_byte_t'({host_i, host_i} >> cfg_i.rotate_amount);
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_plane
      pwr_byte_t src;
      pwr_byte_t mask;
      pwr_byte_t alu;
      pwr_byte_t old;
      assign old = latch_i[8*n +: 8];
      always_comb begin
        case (cfg_i.write_op_select)
          WOP_ROTATED: begin
            src = cfg_i.fill_en[n] ? {8{cfg_i.fill_bits[n]}} : rotated;
            mask = cfg_i.write_bit_protect;
          end
          WOP_BIT_FILL: begin
            src = {8{host_i[n]}};
            mask = cfg_i.write_bit_protect;
          end
          WOP_MASKED_FILL: begin
            src = {8{cfg_i.fill_bits[n]}};
            mask = rotated & cfg_i.write_bit_protect;
          end
          default: begin
            src = old;
            mask = `PWR_MASK_NONE;
          end
        endcase
        // for WOP_ROTATED the rotation is already in src, so it precedes the operation
        case (cfg_i.logic_op)
          OP_AND: alu = src & old;
          OP_OR: alu = src | old;
          OP_XOR: alu = src ^ old;
          default: alu = src;
        endcase
      end
      assign data_o[8*n +: 8] = (alu & mask) | (old & ~mask);
    end
  endgenerate
endmodule : pwr_write_unit
`default_nettype wire

// >>> testbench.sv
// Purpose: self-checking bench of the planar write/read datapath
// Assumes: map model answers one cycle after a map read
// Notes: map contents are preset at time zero and peeked after writes
`timescale 1ns/1ps
`default_nettype none
`include "pwr_cfg.svh"
module testbench;
  import pwr_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] io_addr_i = 16'h0000;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  pwr_byte_t io_wdata_i = 8'h00;
  pwr_byte_t io_rdata_o;
  logic io_rvalid_o;
  logic mem_wr_i = 1'b0;
  logic mem_rd_i = 1'b0;
  logic [19:0] mem_addr_i = 20'h00000;
  pwr_byte_t mem_wdata_i = 8'h00;
  logic seq_chain4_i = 1'b0;
  pwr_byte_t mem_rdata_o;
  logic mem_ack_o;
  logic mem_busy_o;
  pwr_map_req_s map_req_o;
  logic [31:0] map_rdata_i;
  pwr_disp_s disp_o;
  int n_fail = 0;
  int n_compared = 0;
  logic [31:0] latch;
  always #25 clock_i = ~clock_i;
  pwr_datapath dut (.clock_i(clock_i), .reset_i(reset_i), .io_addr_i(io_addr_i),
    .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
    .io_rvalid_o(io_rvalid_o), .mem_wr_i(mem_wr_i), .mem_rd_i(mem_rd_i),
    .mem_addr_i(mem_addr_i), .mem_wdata_i(mem_wdata_i), .seq_chain4_i(seq_chain4_i),
    .mem_rdata_o(mem_rdata_o), .mem_ack_o(mem_ack_o), .mem_busy_o(mem_busy_o),
    .map_req_o(map_req_o), .map_rdata_i(map_rdata_i), .disp_o(disp_o));
  pwr_map_model maps (.clock_i(clock_i), .req_i(map_req_o), .rdata_o(map_rdata_i));
  task automatic report_and_stop;
    $display("compared %0d, mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] pat(input int k);
    return 32'hC3A55A3C ^ {4{8'(k)}};
  endfunction : pat
  function automatic pwr_byte_t rotr(input pwr_byte_t d, input int r);
    return (d >> r) | (d << (8 - r));
  endfunction : rotr
  function automatic pwr_byte_t opf(input pwr_byte_t d, input pwr_byte_t l, input int op);
    case (op)
      1: return d & l;
      2: return d | l;
      3: return d ^ l;
      default: return d;
    endcase
  endfunction : opf
  function automatic pwr_byte_t cmpf(input logic [31:0] w, input logic [3:0] c,
                                     input logic [3:0] m);
    pwr_byte_t r = 8'hFF;
    for (int n = 0; n < 4; n++) begin
      if (m[n]) r &= ~(w[8*n +: 8] ^ {8{c[n]}});
    end
    return r;
  endfunction : cmpf
  function automatic logic [31:0] merge(input logic [31:0] d, input pwr_byte_t m);
    return (d & {4{m}}) | (latch & ~{4{m}});
  endfunction : merge
  task automatic settle;
    @(posedge clock_i);
    #1;
  endtask : settle
  task automatic io_wr(input logic [15:0] a, input pwr_byte_t d);
    @(posedge clock_i);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge clock_i);
    io_wr_i <= 1'b0;
  endtask : io_wr
  task automatic reg_wr(input logic [3:0] i, input pwr_byte_t d);
    io_wr(`PWR_IO_INDEX_PORT, {4'h0, i});
    io_wr(`PWR_IO_DATA_PORT, d);
  endtask : reg_wr
  task automatic io_rd(input logic [15:0] a, input pwr_byte_t exp);
    @(posedge clock_i);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge clock_i);
    io_rd_i <= 1'b0;
    #1;
    chk(io_rvalid_o, 1'b1, "read strobe");
    chk(io_rdata_o, exp, "register read");
  endtask : io_rd
  task automatic mem_op(input logic rd, input logic [19:0] a, input pwr_byte_t d,
                        input logic take, output pwr_byte_t q);
    int k = 0;
    @(posedge clock_i);
    mem_addr_i <= a;
    mem_wdata_i <= d;
    mem_rd_i <= rd;
    mem_wr_i <= !rd;
    @(posedge clock_i);
    mem_rd_i <= 1'b0;
    mem_wr_i <= 1'b0;
    #1;
    chk({mem_busy_o, map_req_o.rd}, {2{rd & take}}, "read issue");
    while (mem_ack_o !== 1'b1 && k < 4) begin
      settle();
      k++;
    end
    q = mem_rdata_o;
    if (take && mem_ack_o !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: no memory acknowledge", $time);
      report_and_stop();
    end else if (take) begin
      chk(k, rd ? 32'(`PWR_READ_LATENCY - 1) : 32'd0, "memory latency");
    end else begin
      chk(mem_ack_o, 1'b0, "refused access");
    end
  endtask : mem_op
  task automatic t_regs;
    pwr_byte_t mask [9] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B, 8'h0F, 8'h0F, 8'hFF};
    for (int i = 0; i < 9; i++) begin
      reg_wr(4'(i), mask[i]);
      io_rd(`PWR_IO_DATA_PORT, mask[i]);
      reg_wr(4'(i), 8'h00);
    end
    io_wr(`PWR_IO_INDEX_PORT, 8'h09);
    io_wr(`PWR_IO_DATA_PORT, 8'hFF);
    io_rd(`PWR_IO_INDEX_PORT, 8'h09);
    io_rd(`PWR_IO_DATA_PORT, 8'h00);
    $display("done: registers");
  endtask : t_regs
  task automatic t_disp;
    pwr_byte_t mv [4] = '{8'h00, 8'h20, 8'h40, 8'h60};
    pwr_load_fmt_e fv [4] = '{LOAD_PLANAR, LOAD_INTERLEAVE, LOAD_WIDE, LOAD_WIDE};
    for (int i = 0; i < 4; i++) begin
      reg_wr(`PWR_IDX_MODE, mv[i]);
      settle();
      chk(disp_o, {fv[i], 2'b00}, "load format");
    end
    reg_wr(`PWR_IDX_MODE, 8'h00);
    reg_wr(`PWR_IDX_WINDOW, 8'h01);
    settle();
    chk(disp_o, {LOAD_PLANAR, 2'b11}, "graphics addressing");
    reg_wr(`PWR_IDX_WINDOW, 8'h00);
    $display("done: display controls");
  endtask : t_disp
  task automatic t_reads;
    logic [3:0] cv [4] = '{4'h5, 4'hA, 4'h0, 4'h0};
    logic [3:0] pv [4] = '{4'hF, 4'h3, 4'h0, 4'hF};
    logic [31:0] w = pat(2);
    pwr_byte_t q;
    for (int f = 0; f < 4; f++) begin
      reg_wr(`PWR_IDX_READ_PLANE, 8'(f));
      mem_op(1'b1, 20'hA0002, 8'h00, 1'b1, q);
      chk(q, w[8*f +: 8], "plane read");
    end
    reg_wr(`PWR_IDX_MODE, 8'h08);
    for (int i = 0; i < 4; i++) begin
      reg_wr(`PWR_IDX_COMPARE, {4'h0, cv[i]});
      reg_wr(`PWR_IDX_PARTICIPATE, {4'h0, pv[i]});
      mem_op(1'b1, 20'hA0000, 8'h00, 1'b1, q);
      chk(q, cmpf(pat(0), cv[i], pv[i]), "compare read");
    end
    reg_wr(`PWR_IDX_MODE, 8'h00);
    $display("done: reads");
  endtask : t_reads
  task automatic t_chain;
    int fld [3] = '{2, 2, 1};
    int off [3] = '{5, 4, 5};
    logic [31:0] w = pat(6);
    pwr_byte_t q;
    @(posedge clock_i);
    seq_chain4_i <= 1'b1;
    mem_op(1'b1, 20'hA0006, 8'h00, 1'b1, q);
    chk(q, w[23:16], "chain-4 read");
    @(posedge clock_i);
    seq_chain4_i <= 1'b0;
    reg_wr(`PWR_IDX_WINDOW, 8'h02);
    w = pat(4);
    for (int i = 0; i < 3; i++) begin
      reg_wr(`PWR_IDX_READ_PLANE, 8'(fld[i]));
      mem_op(1'b1, 20'hA0000 + 20'(off[i]), 8'h00, 1'b1, q);
      chk(q, w[8*((fld[i] & 2) + (off[i] & 1)) +: 8], "paired read");
    end
    mem_op(1'b0, 20'hA0003, 8'h00, 1'b1, q);
    chk({map_req_o.addr, map_req_o.we}, {16'h0002, 4'hA}, "paired write");
    reg_wr(`PWR_IDX_WINDOW, 8'h00);
    reg_wr(`PWR_IDX_MODE, 8'h10);
    w = pat(7);
    mem_op(1'b1, 20'hA0007, 8'h00, 1'b1, q);
    chk(q, w[15:8], "odd/even read");
    reg_wr(`PWR_IDX_MODE, 8'h00);
    $display("done: chained reads");
  endtask : t_chain
  task automatic t_writes;
    pwr_byte_t q;
    pwr_byte_t r = rotr(8'h96, 1);
    logic [31:0] d;
    reg_wr(`PWR_IDX_READ_PLANE, 8'h00);
    mem_op(1'b1, 20'hA0001, 8'h00, 1'b1, q);
    latch = pat(1);
    reg_wr(`PWR_IDX_FILL_VALUE, 8'h01);
    reg_wr(`PWR_IDX_FILL_ENABLE, 8'h01);
    reg_wr(`PWR_IDX_PROTECT, 8'hF0);
    for (int op = 0; op < 4; op++) begin
      reg_wr(`PWR_IDX_ROTATE, 8'(op * 8 + 1));
      mem_op(1'b0, 20'hA0008 + 20'(op), 8'h96, 1'b1, q);
      settle();
      d = {opf(r, latch[31:24], op), opf(r, latch[23:16], op), opf(r, latch[15:8], op),
           opf(8'hFF, latch[7:0], op)};
      chk(maps.store[8 + op], merge(d, 8'hF0), "mode 0 write");
    end
    reg_wr(`PWR_IDX_MODE, 8'h01);
    mem_op(1'b0, 20'hA000C, 8'h00, 1'b1, q);
    settle();
    chk(maps.store[12], latch, "mode 1 write");
    reg_wr(`PWR_IDX_ROTATE, 8'h00);
    reg_wr(`PWR_IDX_PROTECT, 8'hFF);
    reg_wr(`PWR_IDX_MODE, 8'h02);
    mem_op(1'b0, 20'hA000D, 8'h05, 1'b1, q);
    settle();
    chk(maps.store[13], 32'h00FF00FF, "mode 2 write");
    reg_wr(`PWR_IDX_ROTATE, 8'h18);
    mem_op(1'b0, 20'hA000F, 8'h0F, 1'b1, q);
    settle();
    chk(maps.store[15], ~latch, "mode 2 xor write");
    reg_wr(`PWR_IDX_FILL_VALUE, 8'h06);
    reg_wr(`PWR_IDX_PROTECT, 8'h3C);
    reg_wr(`PWR_IDX_ROTATE, 8'h04);
    reg_wr(`PWR_IDX_MODE, 8'h03);
    mem_op(1'b0, 20'hA000E, 8'hF0, 1'b1, q);
    settle();
    chk(maps.store[14], merge(32'h00FFFF00, 8'h0C), "mode 3 write");
    reg_wr(`PWR_IDX_PROTECT, 8'hFF);
    reg_wr(`PWR_IDX_ROTATE, 8'h01);
    reg_wr(`PWR_IDX_FILL_ENABLE, 8'h00);
    reg_wr(`PWR_IDX_MODE, 8'h00);
    mem_op(1'b0, 20'hA0010, 8'h96, 1'b1, q);
    settle();
    chk(maps.store[16], {4{r}}, "mode 0 rotate");
    reg_wr(`PWR_IDX_FILL_ENABLE, 8'h0F);
    mem_op(1'b0, 20'hA0011, 8'h96, 1'b1, q);
    settle();
    chk(maps.store[17], 32'h00FFFF00, "mode 0 fill");
    $display("done: writes");
  endtask : t_writes
  task automatic t_window;
    logic [19:0] bad [4] = '{20'hC0000, 20'hB0000, 20'hB8000, 20'hB0000};
    logic [19:0] base [4] = '{`PWR_BASE_A0000, `PWR_BASE_A0000, `PWR_BASE_B0000,
                              `PWR_BASE_B8000};
    pwr_byte_t q;
    for (int w = 0; w < 4; w++) begin
      reg_wr(`PWR_IDX_WINDOW, 8'(w * 4));
      mem_op(1'b0, bad[w], 8'h00, 1'b0, q);
      mem_op(1'b0, base[w] + 20'h00020, 8'h00, 1'b1, q);
      chk({map_req_o.addr, map_req_o.we}, {16'h0020, 4'hF}, "window offset");
    end
    $display("done: windows");
  endtask : t_window
  initial begin
    for (int k = 0; k < 16; k++) maps.store[k] = pat(k);
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    t_regs();
    t_disp();
    t_reads();
    t_chain();
    t_writes();
    t_window();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
